//--- pkg/fifo_flag_pkg.sv
// constants shared by the flag-timed synchronous fifo and its register bus
package fifo_flag_pkg;

   localparam int          DATA_W         = 9;
   localparam int          DEPTH_DEFAULT  = 64;
   localparam int          OFFSET_W       = 13;
   localparam int          OFFSET_LSB_W   = 8;
   localparam int          OFFSET_MSB_W   = OFFSET_W - OFFSET_LSB_W;
   localparam logic [12:0] OFFSET_DEFAULT = 13'h0007;

   // ahb decode
   localparam int         DEC_W           = 4;
   localparam logic [3:0] EMPTY_OFS_ADDR  = 4'h0;
   localparam logic [3:0] FULL_OFS_ADDR   = 4'h4;
   localparam logic [3:0] STATUS_ADDR     = 4'h8;
   localparam logic [3:0] LEVEL_ADDR      = 4'hc;
   localparam logic [1:0] HRESP_OKAY      = 2'h0;
   localparam int         HTRANS_ACT_BIT  = 1;

   // status register bit positions
   localparam int ST_EMPTY_N  = 0;
   localparam int ST_FULL_N   = 1;
   localparam int ST_AEMPTY_N = 2;
   localparam int ST_AFULL_N  = 3;
   localparam int ST_LOADMODE = 4;
   localparam int ST_IN_RESET = 5;

   // offset load sequence through the pins
   typedef enum logic [3:0] {
      LD_EMPTY_LSB = 4'h1,
      LD_EMPTY_MSB = 4'h2,
      LD_FULL_LSB  = 4'h4,
      LD_FULL_MSB  = 4'h8
   } load_step_e;

endpackage

//--- design/pin_sync2.sv
// two-flop synchroniser for a bundle of pin inputs
`timescale 1ns/1ps
`default_nettype none
module pin_sync2 #(
   parameter int WIDTH = 1
) (
   input  wire logic             hclk,
   input  wire logic             hresetn,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_reg;

   ////////////////////////////////////////////////////////////////////////
   // first stage read only by the second
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         meta_reg <= '0;
         q        <= '0;
      end else begin
         meta_reg <= d;
         q        <= meta_reg;
      end
   end
endmodule
`default_nettype wire

//--- design/word_fifo.sv
// flop-based word fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 32
) (
   input  wire logic                   hclk,
   input  wire logic                   hresetn,
   input  wire logic                   clear,
   input  wire logic                   in_valid,
   output logic                        in_ready,
   input  wire logic [WIDTH-1:0]       in_data,
   output logic                        out_valid,
   input  wire logic                   out_ready,
   output logic      [WIDTH-1:0]       out_data,
   output logic      [$clog2(DEPTH):0] level
);
   localparam int AW = $clog2(DEPTH);

   generate
      if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
         $error("word_fifo depth must be a power of two");
      end
   endgenerate

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW:0]      wr_ptr_reg;
   logic [AW:0]      rd_ptr_reg;
   wire              push = in_valid & in_ready;
   wire              pop  = out_valid & out_ready;

   // honest full and empty from wrapped pointers
   assign level     = wr_ptr_reg - rd_ptr_reg;
   assign in_ready  = (level != (AW+1)'(DEPTH));
   assign out_valid = (level != '0);
   assign out_data  = mem_reg[rd_ptr_reg[AW-1:0]];

   ////////////////////////////////////////////////////////////////////////
   // pointers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
      end else if (clear) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
      end else begin
         if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
         if (pop)  rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
   end

   // storage
   always_ff @(posedge hclk) begin
      if (push) mem_reg[wr_ptr_reg[AW-1:0]] <= in_data;
   end
endmodule
`default_nettype wire

//--- design/flag_fifo_top.sv
// pin-clocked 9-bit fifo with four status flags and an ahb-lite slave
`timescale 1ns/1ps
`default_nettype none
module flag_fifo_top #(
   parameter int DEPTH = fifo_flag_pkg::DEPTH_DEFAULT
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic [1:0]       hresp,
   output logic [31:0]      hrdata,
   input  wire logic        wr_clk_pin,
   input  wire logic        rd_clk_pin,
   input  wire logic        reset_pin_n,
   input  wire logic [8:0]  data_in,
   input  wire logic        write_enable_primary_n,
   input  wire logic        write_enable_second_or_load,
   input  wire logic        read_enable_primary_n,
   input  wire logic        read_enable_second_n,
   input  wire logic        output_enable_n,
   output logic [8:0]       data_out,
   output logic             data_out_en,
   output logic             empty_flag_n,
   output logic             full_flag_n,
   output logic             almost_empty_flag_n,
   output logic             almost_full_flag_n
);
   localparam int PW    = $clog2(DEPTH) + 1;
   localparam int CW    = fifo_flag_pkg::OFFSET_W + 2;
   localparam int DW    = fifo_flag_pkg::DATA_W;
   localparam int LW    = fifo_flag_pkg::OFFSET_LSB_W;
   localparam int MW    = fifo_flag_pkg::OFFSET_MSB_W;
   localparam int SYN_W = DW + 8;

   generate
      if (DEPTH != 64 && DEPTH != 256 && DEPTH != 512 && DEPTH != 1024
          && DEPTH != 2048 && DEPTH != 4096 && DEPTH != 8192) begin : g_bad
         $error("flag_fifo_top depth must be a built configuration");
      end
   endgenerate

   // level must fit the threshold compare beside a full-width offset
   generate
      if (PW > CW - 1) begin : g_bad_width
         $error("flag_fifo_top level too wide for compare");
      end
   endgenerate

   // widen a pointer difference or offset for threshold compares
   function automatic logic [CW-1:0] widen(input logic [CW-2:0] v);
      widen = {1'b0, v};
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers and edge detection
   logic [SYN_W-1:0] pin_raw;
   logic [SYN_W-1:0] pin_s;
   logic             wclk_prev_reg;
   logic             rclk_prev_reg;

   assign pin_raw = {wr_clk_pin, rd_clk_pin, reset_pin_n,
                     write_enable_primary_n, write_enable_second_or_load,
                     read_enable_primary_n, read_enable_second_n,
                     output_enable_n, data_in};

   pin_sync2 #(.WIDTH(SYN_W)) u_sync (
      .hclk    (hclk),
      .hresetn (hresetn),
      .d       (pin_raw),
      .q       (pin_s)
   );

   wire          s_wclk  = pin_s[DW+7];
   wire          s_rclk  = pin_s[DW+6];
   wire          s_rst_n = pin_s[DW+5];
   wire          s_wen1n = pin_s[DW+4];
   wire          s_wen2  = pin_s[DW+3];
   wire          s_ren1n = pin_s[DW+2];
   wire          s_ren2n = pin_s[DW+1];
   wire          s_oen   = pin_s[DW];
   wire [DW-1:0] s_data  = pin_s[DW-1:0];

   // pin clocks may run during device reset, edges are then ignored
   wire dev_rst = ~s_rst_n;
   wire wr_edge = s_wclk & ~wclk_prev_reg & ~dev_rst;
   wire rd_edge = s_rclk & ~rclk_prev_reg & ~dev_rst;

   ////////////////////////////////////////////////////////////////////////
   // state
   logic                    load_mode_reg;
   fifo_flag_pkg::load_step_e ld_step_reg;
   logic [MW+LW-1:0]        empty_ofs_reg;
   logic [MW+LW-1:0]        full_ofs_reg;
   logic [PW-1:0]           wr_total_reg;
   logic [PW-1:0]           rd_total_reg;
   logic [PW-1:0]           wr_seen_reg;
   logic [PW-1:0]           rd_seen_reg;
   logic                    fifo_in_ready;
   logic                    fifo_out_valid;
   logic [DW-1:0]           fifo_out_data;
   logic [PW-1:0]           fifo_level;

   // write and read qualification
   wire fifo_wr = wr_edge & ~s_wen1n & s_wen2 & full_flag_n
                  & fifo_in_ready;
   wire ofs_wr  = wr_edge & ~s_wen1n & ~s_wen2 & load_mode_reg;
   wire fifo_rd = rd_edge & ~s_ren1n & ~s_ren2n & empty_flag_n
                  & fifo_out_valid;

   word_fifo #(.WIDTH(DW), .DEPTH(DEPTH)) u_fifo (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .clear     (dev_rst),
      .in_valid  (fifo_wr),
      .in_ready  (fifo_in_ready),
      .in_data   (s_data),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_rd),
      .out_data  (fifo_out_data),
      .level     (fifo_level)
   );

   ////////////////////////////////////////////////////////////////////////
   // flag arithmetic, each side from its own pointer and a stale copy
   wire [PW-1:0] wr_total_next = wr_total_reg + PW'(fifo_wr);
   wire [PW-1:0] rd_total_next = rd_total_reg + PW'(fifo_rd);
   wire [PW-1:0] lvl_r = wr_seen_reg - rd_total_next;
   wire [PW-1:0] lvl_w = wr_total_next - rd_seen_reg;
   wire [CW-1:0] lvl_w_x = widen((CW-1)'(lvl_w));
   wire [CW-1:0] depth_x = CW'(DEPTH);
   // almost flags judge the count held before this edge's transfer
   wire [PW-1:0] held_r = wr_seen_reg - rd_total_reg;
   wire [PW-1:0] held_w = wr_total_reg - rd_seen_reg;
   wire [CW-1:0] held_r_x = widen((CW-1)'(held_r));
   wire [CW-1:0] held_w_x = widen((CW-1)'(held_w));
   wire [CW-1:0] eofs_x = widen((CW-1)'(empty_ofs_reg));
   wire [CW-1:0] fofs_x = widen((CW-1)'(full_ofs_reg));

   wire empty_n_next  = (lvl_r != '0);
   wire full_n_next   = (lvl_w_x != depth_x);
   wire aempty_n_next = (held_r_x > eofs_x);
   wire afull_n_next  = ((held_w_x + fofs_x)
                         < depth_x);

   ////////////////////////////////////////////////////////////////////////
   // pin clock history and role capture
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wclk_prev_reg <= 1'b0;
         rclk_prev_reg <= 1'b0;
         load_mode_reg <= 1'b0;
      end else begin
         wclk_prev_reg <= s_wclk;
         rclk_prev_reg <= s_rclk;
         if (dev_rst) load_mode_reg <= ~s_wen2;
      end
   end

   // write side: pointer, stale read copy, full flags on write edges
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_total_reg       <= '0;
         rd_seen_reg        <= '0;
         full_flag_n        <= 1'b1;
         almost_full_flag_n <= 1'b1;
      end else if (dev_rst) begin
         wr_total_reg       <= '0;
         rd_seen_reg        <= '0;
         full_flag_n        <= 1'b1;
         almost_full_flag_n <= 1'b1;
      end else if (wr_edge) begin
         wr_total_reg       <= wr_total_next;
         rd_seen_reg        <= rd_total_reg;
         full_flag_n        <= full_n_next;
         almost_full_flag_n <= afull_n_next;
      end
   end

   // read side: pointer, stale write copy, empty flags, data word
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rd_total_reg        <= '0;
         wr_seen_reg         <= '0;
         empty_flag_n        <= 1'b0;
         almost_empty_flag_n <= 1'b0;
         data_out            <= '0;
      end else if (dev_rst) begin
         rd_total_reg        <= '0;
         wr_seen_reg         <= '0;
         empty_flag_n        <= 1'b0;
         almost_empty_flag_n <= 1'b0;
         data_out            <= '0;
      end else if (rd_edge) begin
         rd_total_reg        <= rd_total_next;
         wr_seen_reg         <= wr_total_reg;
         empty_flag_n        <= empty_n_next;
         almost_empty_flag_n <= aempty_n_next;
         if (fifo_rd) data_out <= fifo_out_data;
      end
   end

   // output enable follows the pin, low level drives the data pins
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) data_out_en <= 1'b0;
      else          data_out_en <= ~s_oen;
   end

   ////////////////////////////////////////////////////////////////////////
   // ahb-lite slave: zero wait, registered read data
   logic             wr_pend_reg;
   logic [3:0]       wr_addr_reg;
   logic [31:0]      rd_mux;
   wire              ahb_go = hsel & htrans[fifo_flag_pkg::HTRANS_ACT_BIT]
                              & hready;
   wire [3:0]        dec    = haddr[fifo_flag_pkg::DEC_W-1:0];
   wire              dec_mapped = (haddr[7:fifo_flag_pkg::DEC_W] == '0);
   wire              bus_wr_e = wr_pend_reg
                        & (wr_addr_reg == fifo_flag_pkg::EMPTY_OFS_ADDR);
   wire              bus_wr_f = wr_pend_reg
                        & (wr_addr_reg == fifo_flag_pkg::FULL_OFS_ADDR);
   wire [31:0]       status_word;

   assign status_word = 32'(
      (32'(empty_flag_n)        << fifo_flag_pkg::ST_EMPTY_N)  |
      (32'(full_flag_n)         << fifo_flag_pkg::ST_FULL_N)   |
      (32'(almost_empty_flag_n) << fifo_flag_pkg::ST_AEMPTY_N) |
      (32'(almost_full_flag_n)  << fifo_flag_pkg::ST_AFULL_N)  |
      (32'(load_mode_reg)       << fifo_flag_pkg::ST_LOADMODE) |
      (32'(dev_rst)             << fifo_flag_pkg::ST_IN_RESET));

   // read mux, unmapped reads as zero
   always_comb begin
      rd_mux = '0;
      if (dec_mapped) begin
         case (dec)
            fifo_flag_pkg::EMPTY_OFS_ADDR: rd_mux = 32'(empty_ofs_reg);
            fifo_flag_pkg::FULL_OFS_ADDR:  rd_mux = 32'(full_ofs_reg);
            fifo_flag_pkg::STATUS_ADDR:    rd_mux = status_word;
            fifo_flag_pkg::LEVEL_ADDR:     rd_mux = 32'(fifo_level);
            default:                       rd_mux = '0;
         endcase
      end
   end

   // address phase capture and read data
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= '0;
         hrdata      <= '0;
         hreadyout   <= 1'b0;
         hresp       <= fifo_flag_pkg::HRESP_OKAY;
      end else begin
         hreadyout   <= 1'b1;
         hresp       <= fifo_flag_pkg::HRESP_OKAY;
         wr_pend_reg <= ahb_go & hwrite & dec_mapped;
         if (ahb_go) wr_addr_reg <= dec;
         if (ahb_go & ~hwrite) hrdata <= rd_mux;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // offsets: defaults at reset, bus writes, pin load sequence
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         empty_ofs_reg <= fifo_flag_pkg::OFFSET_DEFAULT;
         full_ofs_reg  <= fifo_flag_pkg::OFFSET_DEFAULT;
         ld_step_reg   <= fifo_flag_pkg::LD_EMPTY_LSB;
      end else if (dev_rst) begin
         empty_ofs_reg <= fifo_flag_pkg::OFFSET_DEFAULT;
         full_ofs_reg  <= fifo_flag_pkg::OFFSET_DEFAULT;
         ld_step_reg   <= fifo_flag_pkg::LD_EMPTY_LSB;
      end else if (bus_wr_e | bus_wr_f) begin
         if (bus_wr_e) empty_ofs_reg <= hwdata[MW+LW-1:0];
         if (bus_wr_f) full_ofs_reg  <= hwdata[MW+LW-1:0];
      end else if (ofs_wr) begin
         case (ld_step_reg)
            fifo_flag_pkg::LD_EMPTY_LSB: begin
               empty_ofs_reg[LW-1:0] <= s_data[LW-1:0];
               ld_step_reg <= fifo_flag_pkg::LD_EMPTY_MSB;
            end
            fifo_flag_pkg::LD_EMPTY_MSB: begin
               empty_ofs_reg[MW+LW-1:LW] <= s_data[MW-1:0];
               ld_step_reg <= fifo_flag_pkg::LD_FULL_LSB;
            end
            fifo_flag_pkg::LD_FULL_LSB: begin
               full_ofs_reg[LW-1:0] <= s_data[LW-1:0];
               ld_step_reg <= fifo_flag_pkg::LD_FULL_MSB;
            end
            fifo_flag_pkg::LD_FULL_MSB: begin
               full_ofs_reg[MW+LW-1:LW] <= s_data[MW-1:0];
               ld_step_reg <= fifo_flag_pkg::LD_EMPTY_LSB;
            end
            default: ld_step_reg <= fifo_flag_pkg::LD_EMPTY_LSB;
         endcase
      end
   end
endmodule
`default_nettype wire

//--- sim/flag_fifo_chk.sv
// concurrent checks on the flag fifo top pins
`timescale 1ns/1ps
`default_nettype none
module flag_fifo_chk (
   input wire logic       hclk,
   input wire logic       hresetn,
   input wire logic       wr_clk_pin,
   input wire logic       rd_clk_pin,
   input wire logic       reset_pin_n,
   input wire logic       output_enable_n,
   input wire logic [8:0] data_out,
   input wire logic       data_out_en,
   input wire logic       empty_flag_n,
   input wire logic       full_flag_n,
   input wire logic       almost_empty_flag_n,
   input wire logic       almost_full_flag_n
);
   logic       wr_q, rd_q;
   logic [3:0] wr_age, rd_age, dev_age;
   wire        wr_rise = wr_clk_pin & ~wr_q;
   wire        rd_rise = rd_clk_pin & ~rd_q;
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   ////////////////////////////////////////////////////////////////////////
   // saturating ages of the last pin clock rise and of device reset
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_q    <= 1'b0;
         rd_q    <= 1'b0;
         wr_age  <= 4'hf;
         rd_age  <= 4'hf;
         dev_age <= 4'h0;
      end else begin
         wr_q    <= wr_clk_pin;
         rd_q    <= rd_clk_pin;
         wr_age  <= wr_rise ? 4'h0 : wr_age + {3'h0, wr_age != 4'hf};
         rd_age  <= rd_rise ? 4'h0 : rd_age + {3'h0, rd_age != 4'hf};
         dev_age <= !reset_pin_n ? 4'h0 : dev_age + {3'h0, dev_age != 4'hf};
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // flags and read data move only shortly after their own pin clock rises
   a_full_own_edge: assert property (
      $changed(full_flag_n) && dev_age > 4'h6 |-> wr_age < 4'h7)
      else $error("full flag moved without a write edge");
   a_empty_own_edge: assert property (
      $changed(empty_flag_n) && dev_age > 4'h6 |-> rd_age < 4'h7)
      else $error("empty flag moved without a read edge");
   a_aempty_own_edge: assert property (
      $changed(almost_empty_flag_n) && dev_age > 4'h6 |-> rd_age < 4'h7)
      else $error("almost-empty flag moved without a read edge");
   a_afull_own_edge: assert property (
      $changed(almost_full_flag_n) && dev_age > 4'h6 |-> wr_age < 4'h7)
      else $error("almost-full flag moved without a write edge");
   a_data_hold: assert property (
      $changed(data_out) && dev_age > 4'h6 |-> rd_age < 4'h7)
      else $error("read data moved without a read edge");
   // flag pairs, reset state and output enable
   a_full_nests_af: assert property (
      !full_flag_n |-> !almost_full_flag_n)
      else $error("full without almost-full");
   a_empty_nests_ae: assert property (
      !empty_flag_n |-> !almost_empty_flag_n)
      else $error("empty without almost-empty");
   a_reset_state: assert property (
      !reset_pin_n [*5] |-> !empty_flag_n && full_flag_n &&
         almost_full_flag_n && !almost_empty_flag_n && data_out == 9'h000)
      else $error("device reset state wrong");
   a_oe_drive: assert property (
      !output_enable_n [*5] |-> data_out_en)
      else $error("data pins not driven with output enable low");
   a_oe_release: assert property (
      output_enable_n [*5] |-> !data_out_en)
      else $error("data pins driven with output enable high");
endmodule
bind flag_fifo_top flag_fifo_chk u_flag_fifo_chk (
   .hclk                (hclk),
   .hresetn             (hresetn),
   .wr_clk_pin          (wr_clk_pin),
   .rd_clk_pin          (rd_clk_pin),
   .reset_pin_n         (reset_pin_n),
   .output_enable_n     (output_enable_n),
   .data_out            (data_out),
   .data_out_en         (data_out_en),
   .empty_flag_n        (empty_flag_n),
   .full_flag_n         (full_flag_n),
   .almost_empty_flag_n (almost_empty_flag_n),
   .almost_full_flag_n  (almost_full_flag_n)
);
`default_nettype wire

//--- sim/pin_agent.sv
// producer and consumer model on the fifo pin side
`timescale 1ns/1ps
`default_nettype none
module pin_agent (
   input  wire logic       hclk,
   input  wire logic [8:0] data_bus,
   output logic            wr_clk_pin,
   output logic            rd_clk_pin,
   output logic      [8:0] data_in,
   output logic            write_enable_primary_n,
   output logic            write_enable_second_or_load,
   output logic            read_enable_primary_n,
   output logic            read_enable_second_n
);
   // idle pins at time zero
   initial begin
      wr_clk_pin                  = 1'b0;
      rd_clk_pin                  = 1'b0;
      data_in                     = 9'h000;
      write_enable_primary_n      = 1'b1;
      write_enable_second_or_load = 1'b1;
      read_enable_primary_n       = 1'b1;
      read_enable_second_n        = 1'b1;
   end
   // role level, held until changed again
   task automatic set_role(input logic lvl);
      @(posedge hclk);
      write_enable_second_or_load <= lvl; // held through reset
   endtask
   // one write clock period, 4 hclk high and 4 low
   task automatic wr_cycle(input logic en, input logic [8:0] d);
      @(posedge hclk);
      write_enable_primary_n <= ~en;
      data_in                <= d;
      @(posedge hclk);
      wr_clk_pin <= 1'b1; // runs even in reset
      repeat (4) @(posedge hclk);
      wr_clk_pin <= 1'b0;
      repeat (4) @(posedge hclk);
      write_enable_primary_n <= 1'b1;
      data_in                <= ~d; // released bus shows no stale word
      @(negedge hclk);
   endtask
   // one read clock period; word taken once settled
   task automatic rd_cycle(input logic en, output logic [8:0] d);
      @(posedge hclk);
      read_enable_primary_n <= ~en;
      read_enable_second_n  <= ~en;
      @(posedge hclk);
      rd_clk_pin <= 1'b1; // runs even in reset
      repeat (4) @(posedge hclk);
      rd_clk_pin <= 1'b0;
      repeat (4) @(posedge hclk);
      read_enable_primary_n <= 1'b1;
      read_enable_second_n  <= 1'b1;
      @(negedge hclk);
      d = data_bus;
   endtask
endmodule
`default_nettype wire

//--- sim/tb_top.sv
// self-checking bench for the flag fifo top
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin \
   total_checks++; \
   if ((a) !== (b)) begin \
      fails++; \
      $display("ERROR at %0t got %h exp %h", $time, (a), (b)); \
   end \
end
module tb_top;
   int          fails, total_checks;
   logic        hclk, hresetn, hsel, hwrite, reset_pin_n, output_enable_n;
   logic [31:0] haddr, hwdata;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   wire  [31:0] hrdata;
   wire  [1:0]  hresp;
   wire  [8:0]  data_in, data_out;
   wire         hreadyout, wclk, rclk, write_enable_primary_n_n, wen2, read_enable_primary_n_n, read_enable_second_n_n;
   wire         oe, ef_n, ff_n, ae_n, af_n;
   wire  [8:0]  data_pin = oe ? data_out : 9'hzzz;
   flag_fifo_top #(.DEPTH(64)) u_flag_fifo_top (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .wr_clk_pin(wclk), .rd_clk_pin(rclk),
      .reset_pin_n(reset_pin_n), .data_in(data_in),
      .write_enable_primary_n(write_enable_primary_n_n), .write_enable_second_or_load(wen2),
      .read_enable_primary_n(read_enable_primary_n_n), .read_enable_second_n(read_enable_second_n_n),
      .output_enable_n(output_enable_n), .data_out(data_out),
      .data_out_en(oe), .empty_flag_n(ef_n), .full_flag_n(ff_n),
      .almost_empty_flag_n(ae_n), .almost_full_flag_n(af_n));
   pin_agent u_pin_agent (
      .hclk(hclk), .data_bus(data_pin), .wr_clk_pin(wclk),
      .rd_clk_pin(rclk), .data_in(data_in), .write_enable_primary_n(write_enable_primary_n_n),
      .write_enable_second_or_load(wen2), .read_enable_primary_n(read_enable_primary_n_n),
      .read_enable_second_n(read_enable_second_n_n));
   ////////////////////////////////////////////////////////////////////////
   // ahb-lite single word transfer, waits on hready both phases
   task automatic ahb(input logic wr, input logic [31:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
      @(posedge hclk);
      hsel   <= 1'b1;
      haddr  <= a;
      htrans <= 2'h2;
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
      hsel <= 1'b0;
   endtask
   task automatic wreg(input logic [3:0] o, input logic [31:0] v);
      logic [31:0] r;
      ahb(1'b1, {28'h0, o}, v, r);
   endtask
   task automatic rchk(input logic [31:0] a, input logic [31:0] e);
      logic [31:0] r;
      ahb(1'b0, a, 32'h0, r);
      `CHK(r, e)
      `CHK(hresp, fifo_flag_pkg::HRESP_OKAY)
   endtask
   // device reset with pin clocks running and role level held
   task automatic reset_dev(input logic lvl);
      logic [8:0] d;
      u_pin_agent.set_role(lvl);
      reset_pin_n <= 1'b0;
      u_pin_agent.wr_cycle(1'b1, 9'h055);
      u_pin_agent.rd_cycle(1'b1, d);
      @(posedge hclk);
      reset_pin_n <= 1'b1;
      repeat (6) @(posedge hclk);
      @(negedge hclk);
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   always #12.5 hclk = ~hclk;
   initial begin
      repeat (20000) @(posedge hclk);
      fails++;
      results();
   end
   // main sequence
   initial begin
      logic [8:0] d;
      {hclk, hresetn, hsel, hwrite, reset_pin_n, output_enable_n} = 6'h0;
      {haddr, hwdata, htrans} = 66'h0;
      hsize = 3'h2;
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      reset_dev(1'b1);
      `CHK({ef_n, ae_n, ff_n, af_n}, 4'h3)
      `CHK(data_pin, 9'h000)
      rchk(32'h0, 32'h7);
      rchk(32'h4, 32'h7);
      rchk(32'h8, 32'ha);
      rchk(32'h10, 32'h0);
      wreg(fifo_flag_pkg::FULL_OFS_ADDR, 32'h9);
      wreg(fifo_flag_pkg::STATUS_ADDR, 32'hff);
      rchk(32'h4, 32'h9);
      rchk(32'h8, 32'ha);
      wreg(fifo_flag_pkg::FULL_OFS_ADDR, 32'h7);
      output_enable_n <= 1'b1;
      repeat (6) @(posedge hclk);
      `CHK(data_pin, 9'hzzz)
      output_enable_n <= 1'b0;
      $display("test defaults done");
      // first word into an empty fifo
      u_pin_agent.wr_cycle(1'b1, 9'h1a5);
      u_pin_agent.rd_cycle(1'b0, d);
      `CHK(ef_n, 1'b0)
      u_pin_agent.rd_cycle(1'b0, d);
      `CHK(ef_n, 1'b1)
      u_pin_agent.rd_cycle(1'b1, d);
      `CHK(d, 9'h1a5)
      u_pin_agent.rd_cycle(1'b0, d);
      `CHK(ef_n, 1'b0)
      u_pin_agent.rd_cycle(1'b1, d);
      `CHK(d, 9'h1a5)
      $display("test first word done");
      // fill to full, watching both almost flags at their thresholds
      for (int i = 0; i < 64; i++) begin
         u_pin_agent.wr_cycle(1'b1, 9'(i * 7 + 3));
         if (i == 6 || i == 7) begin
            u_pin_agent.rd_cycle(1'b0, d);
            `CHK(ae_n, 1'b0)
            u_pin_agent.rd_cycle(1'b0, d);
            `CHK(ae_n, 1'(i == 7))
         end
         if (i >= 55 && i <= 57) begin
            `CHK(af_n, 1'(i != 57))
            rchk(32'hc, 32'(i + 1));
         end
      end
      u_pin_agent.wr_cycle(1'b0, 9'h000);
      `CHK(ff_n, 1'b0)
      u_pin_agent.wr_cycle(1'b1, 9'h1ff);
      rchk(32'hc, 32'd64);
      u_pin_agent.rd_cycle(1'b1, d);
      `CHK(d, 9'h003)
      u_pin_agent.wr_cycle(1'b0, 9'h000);
      `CHK(ff_n, 1'b0)
      u_pin_agent.wr_cycle(1'b0, 9'h000);
      `CHK({ff_n, af_n}, 2'b10)
      for (int i = 1; i < 64; i++) begin
         u_pin_agent.rd_cycle(1'b1, d);
         `CHK(d, 9'(i * 7 + 3))
         if (i == 56 || i == 57) begin
            `CHK(ae_n, 1'(i == 56))
            rchk(32'hc, 32'(63 - i));
         end
      end
      u_pin_agent.rd_cycle(1'b0, d);
      `CHK({ef_n, ae_n}, 2'b00)
      repeat (2) u_pin_agent.wr_cycle(1'b0, 9'h000);
      `CHK(af_n, 1'b1)
      $display("test fill and drain done");
      // load role picked at reset, offsets loaded through the pins
      reset_dev(1'b0);
      rchk(32'h8, 32'h1a);
      u_pin_agent.wr_cycle(1'b1, 9'h003);
      u_pin_agent.wr_cycle(1'b1, 9'h000);
      u_pin_agent.wr_cycle(1'b1, 9'h005);
      u_pin_agent.wr_cycle(1'b1, 9'h000);
      rchk(32'h0, 32'h3);
      rchk(32'h4, 32'h5);
      rchk(32'hc, 32'h0);
      reset_dev(1'b1);
      rchk(32'h0, 32'h7);
      rchk(32'h8, 32'ha);
      $display("test load role done");
      results();
   end
endmodule
`default_nettype wire
